// file: rsi_pkg.sv
// Purpose: shared constants for the reset state initializer
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   reset values follow the per-source initial value table
package rsi_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_FLAGS   = 8'h00;
	localparam logic [7:0] ADDR_WDOG    = 8'h04;
	localparam logic [7:0] ADDR_REMAP   = 8'h08;
	localparam logic [7:0] ADDR_CLKSEL  = 8'h0c;
	localparam logic [7:0] ADDR_TBASE   = 8'h10;
	localparam logic [7:0] ADDR_PORTDIR = 8'h14;
	localparam logic [7:0] ADDR_INTEN   = 8'h18;
	localparam logic [7:0] ADDR_TMREN   = 8'h1c;
	localparam logic [7:0] ADDR_ANASEL  = 8'h20;
	localparam logic [7:0] ADDR_EVSTAT  = 8'h24;
	localparam logic [7:0] ADDR_EVCLR   = 8'h28;
	localparam logic [7:0] ADDR_EVEN    = 8'h2c;

	// flag register layout
	localparam int FLAG_TO_BIT    = 0;
	localparam int FLAG_PD_BIT    = 1;
	localparam int FLAG_CAUSE_LSB = 4;

	// event bits, same layout in status, clear and enable
	localparam int EV_W        = 5;
	localparam int EV_POR      = 0;
	localparam int EV_PIN      = 1;
	localparam int EV_LVR      = 2;
	localparam int EV_WDT_RUN  = 3;
	localparam int EV_WDT_IDLE = 4;

	// register reset values
	localparam logic [7:0] WDOG_RST    = 8'h7a;
	localparam logic [7:0] REMAP_RST   = 8'h50;
	localparam logic [7:0] CLKSEL_RST  = 8'h03;
	localparam logic [7:0] TBASE_RST   = 8'h37;
	localparam logic [7:0] PORTDIR_RST = 8'hff;
	localparam logic [7:0] INTEN_RST   = 8'h00;
	localparam logic [2:0] TMREN_RST   = 3'h0;
	localparam logic [2:0] ANASEL_RST  = 3'h7;

	localparam int TMR_W = 3;
	localparam int ANA_W = 3;
	localparam int REG_W = 8;

	// default hold count; the internal reset stays low one cycle more than this after its source goes away
	localparam int HOLD_CYC_DEF = 4;

	typedef enum logic [2:0] {
		CAUSE_POR,
		CAUSE_PIN,
		CAUSE_LVR,
		CAUSE_WDT_RUN,
		CAUSE_WDT_IDLE
	} rsi_cause_e;

	typedef enum logic {
		ST_HOLD,
		ST_RUN
	} rsi_state_e;

endpackage

// file: rsi_sticky.sv
// Purpose: sticky status bits with set priority over clear
// Assumes: set and clr are single-clock pulses from the same domain
// Notes:   an event in the clearing cycle survives
`timescale 1ns/10ps
module rsi_sticky #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// control
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);

	logic [W-1:0] q_nxt;

	// set wins so a coincident event is not lost
	always_comb begin
		q_nxt = (q & ~clr) | set;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= q_nxt;
		end
	end

endmodule

// file: rsi_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: inputs are quasi-static levels, not pulses
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module rsi_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// shift one stage per edge
	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST;
			q      <= RST;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end

endmodule

// file: rsi_top.sv
// Purpose: reset state initializer; decides flags and initial state per reset source
// Assumes: rst_n is the power-on reset; pin and low-voltage inputs are asynchronous
// Notes:   registers are reached over APB with zero wait states
//
// How it works
// - power-on clears timeout and powerdown flags
// - pin or low-voltage reset keeps both flags
// - running watchdog reset sets timeout, keeps powerdown
// - idle watchdog reset sets both flags
// - power-on disables every interrupt source
// - power-on clears watchdog, counting starts at once
// - power-on switches timer counters off
// - power-on makes ports inputs, analog pins selected
// - power-on puts stack pointer at top
// - every reset clears the program counter
// - full resets load the same register defaults whatever the source
// - idle watchdog keeps registers, clears counter low
// - unknown-state registers are not initialised here
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module rsi_top
	import rsi_pkg::*;
#(
	parameter int         HOLD_CYC  = HOLD_CYC_DEF,
	parameter int         SP_W      = 3,
	parameter logic [2:0] SP_TOP    = 3'h7
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// reset sources
	input  wire logic              external_reset_pin_n,
	input  wire logic              low_voltage_reset,
	input  wire logic              wdt_timeout,
	// core status
	input  wire logic              core_idle,
	input  wire logic              core_halt,
	input  wire logic              core_clr_wdt,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// core control
	output logic                   core_rst_n,
	output logic                   pc_clear,
	output logic                   sp_load,
	output logic      [SP_W-1:0]   sp_load_value,
	output logic                   wdt_clear,
	output logic                   wdt_run,
	// initial state outputs
	output logic      [REG_W-1:0]  watchdog_control,
	output logic      [REG_W-1:0]  pin_remap_control,
	output logic      [REG_W-1:0]  system_clock_select,
	output logic      [REG_W-1:0]  timebase_control,
	output logic      [REG_W-1:0]  port_direction,
	output logic      [REG_W-1:0]  int_enable,
	output logic      [TMR_W-1:0]  timer_enable,
	output logic      [ANA_W-1:0]  analog_input_0_to_2,
	// flags and interrupt
	output logic                   watchdog_timeout_flag,
	output logic                   powerdown_flag,
	output logic                   irq
);

	localparam int CNT_W = $clog2(HOLD_CYC + 1);
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC);

	// synchronised reset pins
	logic [1:0] pin_sync;
	logic       pin_rst_s;
	logic       lvr_s;

	rsi_sync #(
		.W   (2),
		.RST (2'h0)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({low_voltage_reset, ~external_reset_pin_n}),
		.q       (pin_sync)
	);

	assign pin_rst_s = pin_sync[0];
	assign lvr_s     = pin_sync[1];

	// sequencer state
	rsi_state_e       state_r, state_nxt;
	rsi_cause_e       cause_r, cause_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic             src_any;
	logic             apply;

	assign src_any = pin_rst_s | lvr_s | wdt_timeout;
	assign apply   = (state_r == ST_HOLD) && !src_any && (cnt_r == '0);

	// source capture; pin and low voltage outrank a watchdog cause
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		cnt_nxt   = cnt_r;
		unique case (state_r)
			ST_RUN: begin
				if (src_any) begin
					state_nxt = ST_HOLD;
					cnt_nxt   = HOLD_LOAD;
					if (lvr_s) begin
						cause_nxt = CAUSE_LVR;
					end else if (pin_rst_s) begin
						cause_nxt = CAUSE_PIN;
					end else if (core_idle) begin
						cause_nxt = CAUSE_WDT_IDLE;
					end else begin
						cause_nxt = CAUSE_WDT_RUN;
					end
				end
			end
			ST_HOLD: begin
				if (src_any) begin
					cnt_nxt = HOLD_LOAD;
					// power-on stays power-on; a full reset overrides a watchdog cause
					if (cause_r != CAUSE_POR && (lvr_s || pin_rst_s)) begin
						cause_nxt = lvr_s ? CAUSE_LVR : CAUSE_PIN;
					end
				end else if (cnt_r != '0) begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end else begin
					state_nxt = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_HOLD;
			cause_r <= CAUSE_POR;
			cnt_r   <= HOLD_LOAD;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// core held in reset for the whole hold window
	assign core_rst_n    = (state_r == ST_RUN);
	assign sp_load_value = SP_TOP;
	assign wdt_run       = 1'b1;

	// status flags and initial state registers
	logic             to_r, to_nxt;
	logic             pd_r, pd_nxt;
	logic             full_init;
	logic [REG_W-1:0] wdog_r, wdog_nxt;
	logic [REG_W-1:0] remap_r, remap_nxt;
	logic [REG_W-1:0] clksel_r, clksel_nxt;
	logic [REG_W-1:0] tbase_r, tbase_nxt;
	logic [REG_W-1:0] pdir_r, pdir_nxt;
	logic [REG_W-1:0] inten_r, inten_nxt;
	logic [TMR_W-1:0] tmren_r, tmren_nxt;
	logic [ANA_W-1:0] ana_r, ana_nxt;
	logic             pcc_nxt, spl_nxt, wdc_nxt;
	logic [EV_W-1:0]  ev_en_r, ev_en_nxt;
	logic [EV_W-1:0]  ev_set, ev_clr, ev_stat;
	logic             wr_acc;

	assign wr_acc    = psel & penable & pwrite;
	// idle watchdog leaves the register file alone
	assign full_init = apply && (cause_r != CAUSE_WDT_IDLE);

	always_comb begin
		to_nxt     = to_r;
		pd_nxt     = pd_r;
		wdog_nxt   = wdog_r;
		remap_nxt  = remap_r;
		clksel_nxt = clksel_r;
		tbase_nxt  = tbase_r;
		pdir_nxt   = pdir_r;
		inten_nxt  = inten_r;
		tmren_nxt  = tmren_r;
		ana_nxt    = ana_r;
		ev_en_nxt  = ev_en_r;
		// core side flag upkeep while running
		if (core_halt) begin
			pd_nxt = 1'b1;
		end
		if (core_clr_wdt) begin
			to_nxt = 1'b0;
			pd_nxt = 1'b0;
		end
		// software writes
		if (wr_acc) begin
			unique case (paddr)
				ADDR_WDOG:    wdog_nxt   = pwdata[REG_W-1:0];
				ADDR_REMAP:   remap_nxt  = pwdata[REG_W-1:0];
				ADDR_CLKSEL:  clksel_nxt = pwdata[REG_W-1:0];
				ADDR_TBASE:   tbase_nxt  = pwdata[REG_W-1:0];
				ADDR_PORTDIR: pdir_nxt   = pwdata[REG_W-1:0];
				ADDR_INTEN:   inten_nxt  = pwdata[REG_W-1:0];
				ADDR_TMREN:   tmren_nxt  = pwdata[TMR_W-1:0];
				ADDR_ANASEL:  ana_nxt    = pwdata[ANA_W-1:0];
				ADDR_EVEN:    ev_en_nxt  = pwdata[EV_W-1:0];
				default:      ;
			endcase
		end
		// reset apply wins over software: the core is held in reset anyway
		unique case (cause_r)
			CAUSE_POR: begin
				if (apply) begin
					to_nxt = 1'b0;
					pd_nxt = 1'b0;
				end
			end
			CAUSE_PIN, CAUSE_LVR: begin
				if (apply) begin
					to_nxt = to_r;
					pd_nxt = pd_r;
				end
			end
			CAUSE_WDT_RUN: begin
				if (apply) begin
					to_nxt = 1'b1;
					pd_nxt = pd_r;
				end
			end
			CAUSE_WDT_IDLE: begin
				if (apply) begin
					to_nxt = 1'b1;
					pd_nxt = 1'b1;
				end
			end
		endcase
		if (full_init) begin
			wdog_nxt   = WDOG_RST;
			remap_nxt  = REMAP_RST;
			clksel_nxt = CLKSEL_RST;
			tbase_nxt  = TBASE_RST;
			inten_nxt  = INTEN_RST;
			tmren_nxt  = TMREN_RST;
			pdir_nxt   = PORTDIR_RST;
			ana_nxt    = ANASEL_RST;
		end
		// accumulator, pointers and result words live elsewhere, untouched
		pcc_nxt = apply;
		spl_nxt = apply;
		wdc_nxt = apply;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			to_r     <= 1'b0;
			pd_r     <= 1'b0;
			wdog_r   <= WDOG_RST;
			remap_r  <= REMAP_RST;
			clksel_r <= CLKSEL_RST;
			tbase_r  <= TBASE_RST;
			pdir_r   <= PORTDIR_RST;
			inten_r  <= INTEN_RST;
			tmren_r  <= TMREN_RST;
			ana_r    <= ANASEL_RST;
			ev_en_r  <= '0;
			pc_clear <= 1'b0;
			sp_load  <= 1'b0;
			wdt_clear <= 1'b0;
		end else begin
			to_r     <= to_nxt;
			pd_r     <= pd_nxt;
			wdog_r   <= wdog_nxt;
			remap_r  <= remap_nxt;
			clksel_r <= clksel_nxt;
			tbase_r  <= tbase_nxt;
			pdir_r   <= pdir_nxt;
			inten_r  <= inten_nxt;
			tmren_r  <= tmren_nxt;
			ana_r    <= ana_nxt;
			ev_en_r  <= ev_en_nxt;
			pc_clear <= pcc_nxt;
			sp_load  <= spl_nxt;
			wdt_clear <= wdc_nxt;
		end
	end

	assign watchdog_timeout_flag = to_r;
	assign powerdown_flag        = pd_r;
	assign watchdog_control      = wdog_r;
	assign pin_remap_control     = remap_r;
	assign system_clock_select   = clksel_r;
	assign timebase_control      = tbase_r;
	assign port_direction        = pdir_r;
	assign int_enable            = inten_r;
	assign timer_enable          = tmren_r;
	assign analog_input_0_to_2   = ana_r;

	// one event bit per reset kind, raised at the apply cycle
	always_comb begin
		ev_set = '0;
		if (apply) begin
			unique case (cause_r)
				CAUSE_POR:      ev_set[EV_POR]      = 1'b1;
				CAUSE_PIN:      ev_set[EV_PIN]      = 1'b1;
				CAUSE_LVR:      ev_set[EV_LVR]      = 1'b1;
				CAUSE_WDT_RUN:  ev_set[EV_WDT_RUN]  = 1'b1;
				CAUSE_WDT_IDLE: ev_set[EV_WDT_IDLE] = 1'b1;
			endcase
		end
		ev_clr = (wr_acc && paddr == ADDR_EVCLR) ? pwdata[EV_W-1:0] : '0;
	end

	rsi_sticky #(
		.W (EV_W)
	) u_events (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.set     (ev_set),
		.clr     (ev_clr),
		.q       (ev_stat)
	);

	assign irq = |(ev_stat & ev_en_r);

	// apb read path: data captured in setup, shown in the access cycle
	logic [31:0] rdata_nxt;
	logic        err_nxt;
	logic        hit;

	always_comb begin
		rdata_nxt = prdata;
		err_nxt   = pslverr;
		hit       = 1'b1;
		unique case (paddr)
			ADDR_FLAGS:   rdata_nxt = {25'h0, cause_r, 2'h0, pd_r, to_r};
			ADDR_WDOG:    rdata_nxt = {24'h0, wdog_r};
			ADDR_REMAP:   rdata_nxt = {24'h0, remap_r};
			ADDR_CLKSEL:  rdata_nxt = {24'h0, clksel_r};
			ADDR_TBASE:   rdata_nxt = {24'h0, tbase_r};
			ADDR_PORTDIR: rdata_nxt = {24'h0, pdir_r};
			ADDR_INTEN:   rdata_nxt = {24'h0, inten_r};
			ADDR_TMREN:   rdata_nxt = {29'h0, tmren_r};
			ADDR_ANASEL:  rdata_nxt = {29'h0, ana_r};
			ADDR_EVSTAT:  rdata_nxt = {27'h0, ev_stat};
			ADDR_EVCLR:   rdata_nxt = 32'h0;
			ADDR_EVEN:    rdata_nxt = {27'h0, ev_en_r};
			default: begin
				rdata_nxt = 32'h0;
				hit       = 1'b0;
			end
		endcase
		if (psel && !penable) begin
			err_nxt = !hit;
		end else begin
			rdata_nxt = prdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= rdata_nxt;
			pslverr <= err_nxt;
		end
	end

	// zero wait states; unmapped access ends with pslverr
	assign pready = 1'b1;

endmodule

// file: rsi_top_bench.sv
// Purpose: self-checking bench for the reset state initializer
// Assumes: zero wait state apb, HOLD_CYC left at its default
// Notes:   outputs are sampled 1 ns after the edge so updates have landed, except in apb, which reads pready, prdata and pslverr at the edge
`timescale 1ns/10ps
module rsi_top_bench import rsi_pkg::*; ;
	logic        ref_clk, rst_n, external_reset_pin_n, low_voltage_reset, wdt_timeout;
	logic        core_idle, core_halt, core_clr_wdt, psel, penable, pwrite, err;
	logic [7:0]  paddr, watchdog_control, pin_remap_control, system_clock_select;
	logic [7:0]  timebase_control, port_direction, int_enable;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, core_rst_n, pc_clear, sp_load, wdt_clear, wdt_run, irq;
	logic [2:0]  sp_load_value, timer_enable, analog_input_0_to_2;
	logic        watchdog_timeout_flag, powerdown_flag;
	int          error_cnt, compares;

	rsi_top u_dut (.ref_clk, .rst_n, .external_reset_pin_n, .low_voltage_reset,
		.wdt_timeout, .core_idle, .core_halt, .core_clr_wdt, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .core_rst_n, .pc_clear, .sp_load,
		.sp_load_value, .wdt_clear, .wdt_run, .watchdog_control, .pin_remap_control,
		.system_clock_select, .timebase_control, .port_direction, .int_enable,
		.timer_enable, .analog_input_0_to_2, .watchdog_timeout_flag, .powerdown_flag, .irq);

	// clock, 100 ns period
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task stop_test;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers must not slip through silently
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("mismatch %0t no ready on apb", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, m);
	endtask

	// wait, bounded, for the core to leave reset
	task wait_up;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (core_rst_n !== 1'b1 && n < 40);
		chk(core_rst_n, 1'b1, "core stuck in reset");
		chk(pc_clear, 1'b1, "no counter clear");
	endtask

	// k: 0 pin, 1 low voltage, 2 watchdog; then expected flags and control
	task hit(input int k, input logic idle, input logic to, input logic pd, input logic [7:0] wc);
		@(posedge ref_clk);
		core_idle <= idle;
		external_reset_pin_n <= (k != 0);
		low_voltage_reset <= (k == 1);
		wdt_timeout <= (k == 2);
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		repeat (3) @(posedge ref_clk);
		external_reset_pin_n <= 1'b1;
		low_voltage_reset <= 1'b0;
		wait_up();
		chk({watchdog_timeout_flag, powerdown_flag}, {to, pd}, "flags");
		chk(watchdog_control, wc, "watchdog control");
	endtask

	task t_por;
		wait_up();
		chk({watchdog_timeout_flag, powerdown_flag}, 2'b00, "por flags");
		chk(int_enable, INTEN_RST, "int enable");
		chk(timer_enable, TMREN_RST, "timers");
		chk({port_direction, analog_input_0_to_2}, {PORTDIR_RST, ANASEL_RST}, "ports");
		chk({wdt_clear, wdt_run}, 2'b11, "watchdog restart");
		chk({sp_load, sp_load_value}, {1'b1, 3'h7}, "stack");
		chk({watchdog_control, pin_remap_control, system_clock_select, timebase_control},
			{WDOG_RST, REMAP_RST, CLKSEL_RST, TBASE_RST}, "defaults");
		rdc(ADDR_FLAGS, 32'h0, "flag register");
		chk(irq, 1'b0, "irq before enable");
	endtask

	task t_regs;
		apb(1'b1, ADDR_FLAGS, 32'h3);
		rdc(ADDR_FLAGS, 32'h0, "flags written");
		apb(1'b1, 8'h30, 32'h1);
		chk(err, 1'b1, "unmapped error");
		rdc(ADDR_PORTDIR, 32'hff, "port direction");
		apb(1'b1, ADDR_EVEN, 32'h1);
		chk(irq, 1'b1, "irq enabled");
		apb(1'b1, ADDR_EVEN, 32'h0);
		chk(irq, 1'b0, "irq masked");
		apb(1'b1, ADDR_EVEN, 32'h1);
		apb(1'b1, ADDR_EVCLR, 32'h1);
		chk(irq, 1'b0, "irq cleared");
		rdc(ADDR_EVSTAT, 32'h0, "status cleared");
	endtask

	task flag_pulse(input logic halt);
		@(posedge ref_clk);
		core_halt <= halt;
		core_clr_wdt <= !halt;
		@(posedge ref_clk);
		core_halt <= 1'b0;
		core_clr_wdt <= 1'b0;
		#1;
	endtask

	initial begin
		{external_reset_pin_n, low_voltage_reset, wdt_timeout, core_idle} = 4'b1000;
		{core_halt, core_clr_wdt, psel, penable, pwrite, rst_n} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_por();
		t_regs();
		flag_pulse(1'b1);
		apb(1'b1, ADDR_WDOG, 32'h11);
		hit(0, 1'b0, 1'b0, 1'b1, WDOG_RST);
		apb(1'b1, ADDR_WDOG, 32'h11);
		hit(2, 1'b0, 1'b1, 1'b1, WDOG_RST);
		apb(1'b1, ADDR_WDOG, 32'h11);
		hit(1, 1'b0, 1'b1, 1'b1, WDOG_RST);
		flag_pulse(1'b0);
		apb(1'b1, ADDR_WDOG, 32'h22);
		hit(2, 1'b1, 1'b1, 1'b1, 8'h22);
		rdc(ADDR_FLAGS, 32'h43, "idle cause");
		// second power-on with both flags and a custom control value set
		@(posedge ref_clk);
		rst_n <= 1'b0;
		core_idle <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_por();
		stop_test();
	end

	// a full run takes far less than this span
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
endmodule

// file: rsi_top_sva.sv
// Purpose: checker for the reset state initializer top ports
// Assumes: one clock domain, rst_n is the power-on reset
// Notes:   bound to every rsi_top instance
`timescale 1ns/10ps
module rsi_top_sva
	import rsi_pkg::*;
#(
	parameter int         SP_W   = 3,
	parameter logic [2:0] SP_TOP = 3'h7
) (
	// clock and reset
	input wire logic             ref_clk,
	input wire logic             rst_n,
	// sources
	input wire logic             wdt_timeout,
	input wire logic             core_idle,
	// core control
	input wire logic             core_rst_n,
	input wire logic             pc_clear,
	input wire logic             sp_load,
	input wire logic [SP_W-1:0]  sp_load_value,
	input wire logic             wdt_clear,
	input wire logic             wdt_run,
	// state
	input wire logic [REG_W-1:0] watchdog_control,
	input wire logic [REG_W-1:0] int_enable,
	input wire logic [REG_W-1:0] port_direction,
	input wire logic [TMR_W-1:0] timer_enable,
	input wire logic [ANA_W-1:0] analog_input_0_to_2,
	input wire logic             watchdog_timeout_flag,
	input wire logic             powerdown_flag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// a watchdog hit only counts while the core is running
	sequence s_wdt_hit;
		wdt_timeout && core_rst_n;
	endsequence
	sequence s_exit;
		$rose(core_rst_n);
	endsequence

	// release of internal reset carries the restart pulses
	a_exit_pulses: assert property (s_exit |-> pc_clear && sp_load)
		else $error("restart pulses missing at reset exit");
	a_pulse_once: assert property (pc_clear |=> !pc_clear)
		else $error("program counter clear longer than one cycle");
	a_stack_top: assert property (sp_load |-> sp_load_value == SP_TOP)
		else $error("stack pointer not loaded with top");
	a_wdt_restart: assert property (s_exit |-> wdt_clear ##1 (wdt_run && !wdt_clear))
		else $error("watchdog not cleared and running");
	a_wdt_enters: assert property (s_wdt_hit |=> !core_rst_n)
		else $error("watchdog hit did not reset core");
	a_wdt_sets_to: assert property (s_wdt_hit |-> ##[2:30] (core_rst_n && watchdog_timeout_flag))
		else $error("timeout flag not set after watchdog reset");
	a_idle_sets_pd: assert property (s_wdt_hit ##0 core_idle |-> ##[2:30] (core_rst_n && powerdown_flag))
		else $error("powerdown flag not set after idle watchdog reset");
	// without powerdown set the reset was a full one, so defaults must be loaded
	a_full_defaults: assert property ($rose(core_rst_n) && !powerdown_flag |->
		watchdog_control == WDOG_RST && int_enable == INTEN_RST &&
		port_direction == PORTDIR_RST && timer_enable == TMREN_RST &&
		analog_input_0_to_2 == ANASEL_RST)
		else $error("defaults not loaded after full reset");
endmodule

bind rsi_top rsi_top_sva #(.SP_W(SP_W), .SP_TOP(SP_TOP)) u_sva (.ref_clk, .rst_n,
	.wdt_timeout, .core_idle, .core_rst_n, .pc_clear, .sp_load, .sp_load_value,
	.wdt_clear, .wdt_run, .watchdog_control, .int_enable, .port_direction,
	.timer_enable, .analog_input_0_to_2, .watchdog_timeout_flag, .powerdown_flag);
